/* flash_cmd_decoder.sv */
// Flash-side serial command decoder, link logic on the serial clock, events crossed to i_mclk
// Summary of operation
// - Opcode 0B: three address bytes, eight dummies, stream
// - Opcode 0C: four address bytes, eight dummies, stream
// - Opcode B0 pauses program or erase
// - Opcode 30 continues paused program or erase
// - Opcode AB releases deep power down
// - Opcode E4 erases all persistent protect bits
// - Opcode 16 returns the four boot bytes, repeating them for as long as the host clocks
// - Host sends opcode 17 plus four data bytes
// - Opcode 18 erases the boot register
// - Reset fires only after accepted arm command
// - Any command between arm and fire disarms
// - Host sends any opcode it is given, defined or not
// - Invalid sequence: standby, output off until reselect
// - Sample rising edge, shift out falling edge
// - Altering commands need write latch flag set
// - Deep sleep accepts only wake and reset
module flash_cmd_decoder (
  spi_link_if.device        link,
  input  wire logic         i_mclk,
  input  wire logic         i_nrst,
  output logic [flash_cmd_pkg::N_EV-1:0] o_op_pulse,
  output logic              o_deep_sleep,
  output logic              o_write_latch,
  output logic [31:0]       o_boot_value
);
  typedef enum logic [2:0] {
    ST_OP     = 3'h0,
    ST_ADDR   = 3'h1,
    ST_DUMMY  = 3'h2,
    ST_DATA   = 3'h3,
    ST_DONE   = 3'h4,
    ST_IGNORE = 3'h5
  } phase_e;

  phase_e      state;
  logic [5:0]  cnt;
  logic [7:0]  shift;
  logic [7:0]  op;
  logic [31:0] addr;
  logic [31:0] wbuf;
  logic [2:0]  dbit;
  logic [1:0]  dbyte;
  logic        write_latch_flag;
  logic        dpd;
  logic        armed;
  logic [31:0] boot_reg;
  logic [flash_cmd_pkg::N_EV-1:0] ev_tog;

  // Frame logic is held in reset while deselected, so every frame starts at the opcode
  wire frame_rst_n = i_nrst & ~link.cs_n;
  wire [7:0] op_now = {shift[6:0], link.mosi};
  wire op_done = (state == ST_OP) && (cnt == 6'd7);

  wire known = op_now inside {flash_cmd_pkg::OP_FAST_READ_THREE_BYTE_ADDR, flash_cmd_pkg::OP_FAST_READ_FOUR_BYTE_ADDR,
                              flash_cmd_pkg::OP_PROGRAM_ERASE_PAUSE, flash_cmd_pkg::OP_PROGRAM_ERASE_CONTINUE,
                              flash_cmd_pkg::OP_POWER_DOWN_RELEASE, flash_cmd_pkg::OP_DEEP_SLEEP_ENTER,
                              flash_cmd_pkg::OP_PERSISTENT_PROTECT_ERASE_ALL, flash_cmd_pkg::OP_BOOT_REG_READ,
                              flash_cmd_pkg::OP_BOOT_REG_WRITE, flash_cmd_pkg::OP_BOOT_REG_ERASE,
                              flash_cmd_pkg::OP_RESET_ARM_CMD, flash_cmd_pkg::OP_RESET_FIRE_CMD,
                              flash_cmd_pkg::OP_WRITE_LATCH_SET_CMD, flash_cmd_pkg::OP_WRITE_LATCH_CLEAR_CMD};
  wire sleep_ok = op_now inside {flash_cmd_pkg::OP_POWER_DOWN_RELEASE, flash_cmd_pkg::OP_RESET_ARM_CMD,
                                 flash_cmd_pkg::OP_RESET_FIRE_CMD};
  wire alters = op_now inside {flash_cmd_pkg::OP_PERSISTENT_PROTECT_ERASE_ALL, flash_cmd_pkg::OP_BOOT_REG_WRITE,
                               flash_cmd_pkg::OP_BOOT_REG_ERASE};
  // Unknown codes, sleep-blocked codes and unlatched writes all drop to standby
  wire accept = known && (!dpd || sleep_ok) && (!alters || write_latch_flag);
  wire take = op_done && accept;
  wire fire_ok = take && (op_now == flash_cmd_pkg::OP_RESET_FIRE_CMD) && armed;
  wire boot_wr_done = (state == ST_DATA) && (op == flash_cmd_pkg::OP_BOOT_REG_WRITE) &&
                      (dbit == 3'd7) && (dbyte == flash_cmd_pkg::BOOT_LAST_BYTE);
  wire [31:0] boot_in = {wbuf[30:0], link.mosi};

  wire [5:0] addr_bits = flash_cmd_pkg::cmd_addr_bits(op);
  wire [5:0] dummy_bits = flash_cmd_pkg::cmd_dummy_bits(op);
  wire [flash_cmd_pkg::N_EV-1:0] ev_hit;
  assign ev_hit[flash_cmd_pkg::EV_PAUSE]      = take && op_now == flash_cmd_pkg::OP_PROGRAM_ERASE_PAUSE;
  assign ev_hit[flash_cmd_pkg::EV_CONTINUE]   = take && op_now == flash_cmd_pkg::OP_PROGRAM_ERASE_CONTINUE;
  assign ev_hit[flash_cmd_pkg::EV_WAKE]       = take && op_now == flash_cmd_pkg::OP_POWER_DOWN_RELEASE;
  assign ev_hit[flash_cmd_pkg::EV_SLEEP]      = take && op_now == flash_cmd_pkg::OP_DEEP_SLEEP_ENTER;
  assign ev_hit[flash_cmd_pkg::EV_PROT_ERASE] = take && op_now == flash_cmd_pkg::OP_PERSISTENT_PROTECT_ERASE_ALL;
  assign ev_hit[flash_cmd_pkg::EV_BOOT_WRITE] = boot_wr_done;
  assign ev_hit[flash_cmd_pkg::EV_BOOT_ERASE] = take && op_now == flash_cmd_pkg::OP_BOOT_REG_ERASE;
  assign ev_hit[flash_cmd_pkg::EV_MEM_RESET]  = fire_ok;

  // Output byte: boot register MSB byte first, otherwise the running array address
  wire [31:0] boot_sh = boot_reg << {dbyte, 3'h0};
  wire [7:0] out_byte = (op == flash_cmd_pkg::OP_BOOT_REG_READ) ? boot_sh[31:24] : addr[7:0];
  wire rd_phase = (state == ST_DATA) && flash_cmd_pkg::cmd_is_read(op);

  // State that outlives a frame; a command takes effect once its opcode byte is complete, a boot write after its fourth data byte
  always_ff @(posedge link.sclk or negedge i_nrst) begin
    if (!i_nrst) begin
      write_latch_flag <= 1'b0;
      dpd <= 1'b0;
      armed <= 1'b0;
      boot_reg <= flash_cmd_pkg::BOOT_RESET;
      ev_tog <= '0;
    end else begin
      ev_tog <= ev_tog ^ ev_hit;
      if (op_done) begin
        armed <= take && (op_now == flash_cmd_pkg::OP_RESET_ARM_CMD);
      end
      if (take) begin
        case (op_now)
          flash_cmd_pkg::OP_WRITE_LATCH_SET_CMD: write_latch_flag <= 1'b1;
          flash_cmd_pkg::OP_WRITE_LATCH_CLEAR_CMD: write_latch_flag <= 1'b0;
          flash_cmd_pkg::OP_DEEP_SLEEP_ENTER: dpd <= 1'b1;
          flash_cmd_pkg::OP_POWER_DOWN_RELEASE: dpd <= 1'b0;
          flash_cmd_pkg::OP_PERSISTENT_PROTECT_ERASE_ALL: write_latch_flag <= 1'b0;
          flash_cmd_pkg::OP_BOOT_REG_ERASE: begin
            write_latch_flag <= 1'b0;
            boot_reg <= flash_cmd_pkg::BOOT_ERASED;
          end
          flash_cmd_pkg::OP_RESET_FIRE_CMD: begin
            if (armed) begin
              write_latch_flag <= 1'b0;
              dpd <= 1'b0;
            end
          end
          default: ;
        endcase
      end
      if (boot_wr_done) begin
        boot_reg <= boot_in;
        write_latch_flag <= 1'b0;
      end
    end
  end

  // Frame sequencer, input sampled on the rising serial clock
  always_ff @(posedge link.sclk or negedge frame_rst_n) begin
    if (!frame_rst_n) begin
      state <= ST_OP;
      cnt <= '0;
      shift <= '0;
      op <= '0;
      addr <= '0;
      wbuf <= '0;
      dbit <= '0;
      dbyte <= '0;
    end else begin
      case (state)
        ST_OP: begin
          shift <= op_now;
          cnt <= cnt + 6'd1;
          if (cnt == 6'd7) begin
            op <= op_now;
            cnt <= '0;
            if (!accept) begin
              state <= ST_IGNORE;
            end else if (flash_cmd_pkg::cmd_addr_bits(op_now) != 6'd0) begin
              state <= ST_ADDR;
            end else if (op_now == flash_cmd_pkg::OP_BOOT_REG_READ || op_now == flash_cmd_pkg::OP_BOOT_REG_WRITE) begin
              state <= ST_DATA;
            end else begin
              state <= ST_DONE;
            end
          end
        end
        ST_ADDR: begin
          addr <= {addr[30:0], link.mosi};
          cnt <= cnt + 6'd1;
          if (cnt == addr_bits - 6'd1) begin
            cnt <= '0;
            state <= ST_DUMMY;
          end
        end
        ST_DUMMY: begin
          cnt <= cnt + 6'd1;
          if (cnt == dummy_bits - 6'd1) begin
            state <= ST_DATA;
          end
        end
        ST_DATA: begin
          dbit <= dbit + 3'd1;
          wbuf <= boot_in;
          if (dbit == 3'd7) begin
            dbyte <= dbyte + 2'd1;
            addr <= addr + 32'h00000001;
            // Extra clocks after the fourth boot byte are not taken as data
            if (boot_wr_done) begin
              state <= ST_DONE;
            end
          end
        end
        default: ;
      endcase
    end
  end

  // Output shifted on the falling serial clock; off whenever not in a read data phase
  always_ff @(negedge link.sclk or negedge frame_rst_n) begin
    if (!frame_rst_n) begin
      link.miso_oe <= 1'b0;
      link.miso <= 1'b0;
    end else begin
      link.miso_oe <= rd_phase;
      link.miso <= out_byte[~dbit];
    end
  end

  // Toggle-and-sync crossing of each event into i_mclk; first stage feeds only the second
  genvar g;
  generate
    for (g = 0; g < flash_cmd_pkg::N_EV; g++) begin : g_ev
      logic [2:0] sync;
      always_ff @(posedge i_mclk or negedge i_nrst) begin
        if (!i_nrst) begin
          sync <= '0;
          o_op_pulse[g] <= 1'b0;
        end else begin
          sync <= {sync[1:0], ev_tog[g]};
          o_op_pulse[g] <= sync[2] ^ sync[1];
        end
      end
    end
  endgenerate

  // Level flags cross by three flops; the boot word is loaded on the boot write or boot erase pulse and is stable long before it
  logic [1:0] dpd_sync;
  logic [1:0] latch_sync;
  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      dpd_sync <= '0;
      latch_sync <= '0;
      o_deep_sleep <= 1'b0;
      o_write_latch <= 1'b0;
      o_boot_value <= flash_cmd_pkg::BOOT_RESET;
    end else begin
      dpd_sync <= {dpd_sync[0], dpd};
      latch_sync <= {latch_sync[0], write_latch_flag};
      o_deep_sleep <= dpd_sync[1];
      o_write_latch <= latch_sync[1];
      if (o_op_pulse[flash_cmd_pkg::EV_BOOT_WRITE] || o_op_pulse[flash_cmd_pkg::EV_BOOT_ERASE]) begin
        o_boot_value <= boot_reg;
      end
    end
  end
endmodule

/* flash_cmd_pkg.sv */
// Shared opcodes, phase lengths and event indices of the serial flash command decoder
package flash_cmd_pkg;
  localparam logic [7:0] OP_FAST_READ_THREE_BYTE_ADDR   = 8'h0B;
  localparam logic [7:0] OP_FAST_READ_FOUR_BYTE_ADDR    = 8'h0C;
  localparam logic [7:0] OP_PROGRAM_ERASE_PAUSE         = 8'hB0;
  localparam logic [7:0] OP_PROGRAM_ERASE_CONTINUE      = 8'h30;
  localparam logic [7:0] OP_POWER_DOWN_RELEASE          = 8'hAB;
  localparam logic [7:0] OP_DEEP_SLEEP_ENTER            = 8'hB9;
  localparam logic [7:0] OP_PERSISTENT_PROTECT_ERASE_ALL = 8'hE4;
  localparam logic [7:0] OP_BOOT_REG_READ               = 8'h16;
  localparam logic [7:0] OP_BOOT_REG_WRITE              = 8'h17;
  localparam logic [7:0] OP_BOOT_REG_ERASE              = 8'h18;
  localparam logic [7:0] OP_RESET_ARM_CMD               = 8'h66;
  localparam logic [7:0] OP_RESET_FIRE_CMD              = 8'h99;
  localparam logic [7:0] OP_WRITE_LATCH_SET_CMD         = 8'h06;
  localparam logic [7:0] OP_WRITE_LATCH_CLEAR_CMD       = 8'h04;

  localparam logic [5:0]  OPCODE_BITS    = 6'd8;
  localparam logic [5:0]  ADDR3_BITS     = 6'd24;
  localparam logic [5:0]  ADDR4_BITS     = 6'd32;
  localparam logic [5:0]  FAST_DUMMY     = 6'd8;
  localparam logic [1:0]  BOOT_LAST_BYTE = 2'd3;
  localparam logic [31:0] BOOT_ERASED    = 32'hFFFFFFFF;
  localparam logic [31:0] BOOT_RESET     = 32'hFFFFFFFF;

  // Event indices of the one-cycle operation pulses
  localparam int EV_PAUSE     = 0;
  localparam int EV_CONTINUE  = 1;
  localparam int EV_WAKE      = 2;
  localparam int EV_SLEEP     = 3;
  localparam int EV_PROT_ERASE = 4;
  localparam int EV_BOOT_WRITE = 5;
  localparam int EV_BOOT_ERASE = 6;
  localparam int EV_MEM_RESET = 7;
  localparam int N_EV         = 8;

  localparam int SCLK_HALF    = 4;

  function automatic logic [5:0] cmd_addr_bits(input logic [7:0] op);
    cmd_addr_bits = (op == OP_FAST_READ_FOUR_BYTE_ADDR) ? ADDR4_BITS :
                    (op == OP_FAST_READ_THREE_BYTE_ADDR) ? ADDR3_BITS : 6'd0;
  endfunction

  function automatic logic [5:0] cmd_dummy_bits(input logic [7:0] op);
    cmd_dummy_bits = (op == OP_FAST_READ_FOUR_BYTE_ADDR || op == OP_FAST_READ_THREE_BYTE_ADDR) ?
                     FAST_DUMMY : 6'd0;
  endfunction

  function automatic logic cmd_is_read(input logic [7:0] op);
    cmd_is_read = (op == OP_FAST_READ_FOUR_BYTE_ADDR) || (op == OP_FAST_READ_THREE_BYTE_ADDR) ||
                  (op == OP_BOOT_REG_READ);
  endfunction
endpackage

/* flash_cmd_sva.sv */
// Link-level assertions for the serial flash command link, sampled on the user clock
module flash_cmd_sva (
  input wire logic i_mclk,
  input wire logic i_nrst,
  input wire logic cs_n,
  input wire logic sclk,
  input wire logic mosi,
  input wire logic miso,
  input wire logic miso_oe,
  input wire logic miso_line
);
  timeunit 1ns;
  timeprecision 1ps;

  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_nrst);

  logic       sclk_q;
  logic [7:0] nrise;
  logic [7:0] op;
  logic       phase_ok;

  // Count rising link edges and capture the opcode; a deselect restarts the frame
  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      sclk_q <= 1'b0;
      nrise  <= 8'h00;
      op     <= 8'h00;
    end else begin
      sclk_q <= sclk;
      if (cs_n) begin
        nrise <= 8'h00;
        op    <= 8'h00;
      end else if (sclk && !sclk_q) begin
        nrise <= nrise + {7'h00, nrise != 8'hFF};  // Saturate so long streams never wrap
        if (nrise < 8'h08) op <= {op[6:0], mosi};
      end
    end
  end

  // Output may only be on once the whole header of a read command has gone by
  assign phase_ok = (op == flash_cmd_pkg::OP_BOOT_REG_READ && nrise >= 8'(flash_cmd_pkg::OPCODE_BITS)) ||
                    (op == flash_cmd_pkg::OP_FAST_READ_THREE_BYTE_ADDR &&
                     nrise >= 8'(flash_cmd_pkg::OPCODE_BITS + flash_cmd_pkg::ADDR3_BITS + flash_cmd_pkg::FAST_DUMMY)) ||
                    (op == flash_cmd_pkg::OP_FAST_READ_FOUR_BYTE_ADDR &&
                     nrise >= 8'(flash_cmd_pkg::OPCODE_BITS + flash_cmd_pkg::ADDR4_BITS + flash_cmd_pkg::FAST_DUMMY));

  a_read_phase_gate: assert property (miso_oe |-> phase_ok)
    else $error("data output enabled outside a read data phase");
  a_oe_off_deselect: assert property (cs_n |-> !miso_oe)
    else $error("data output driven while deselected");
  a_line_pull_high: assert property (!miso_oe |-> miso_line)
    else $error("released data line not high");
  a_sclk_idle_low: assert property (cs_n |-> !sclk)
    else $error("link clock not idle low outside a frame");
  a_mosi_stable_rise: assert property ($rose(sclk) |-> $stable(mosi))
    else $error("host data changed at the sampling edge");
  a_miso_on_fall: assert property ($changed(miso) && miso_oe && $past(miso_oe) |-> $fell(sclk))
    else $error("device data changed off the falling edge");
  a_oe_rise_fall: assert property ($rose(miso_oe) |-> $fell(sclk) && !cs_n)
    else $error("data output turned on off a falling edge");
  a_sclk_half_len: assert property (!cs_n && $changed(sclk) |=> $stable(sclk)[*3])
    else $error("link clock half period too short");
  a_cs_gap_min: assert property ($rose(cs_n) |-> cs_n[*6])
    else $error("deselect gap too short");
endmodule

/* flash_host_ctrl.sv */
// Host-side serial controller: divides i_mclk into the link clock and frames one command per request
module flash_host_ctrl #(
  parameter int HALF = flash_cmd_pkg::SCLK_HALF
) (
  spi_link_if.host          link,
  input  wire logic         i_mclk,
  input  wire logic         i_nrst,
  input  wire logic         i_start,
  input  wire logic [7:0]   i_opcode,
  input  wire logic [31:0]  i_addr,
  input  wire logic [31:0]  i_wdata,
  input  wire logic [15:0]  i_rd_bytes,
  output logic              o_busy,
  output logic [7:0]        o_rdata,
  output logic              o_rvalid,
  output logic              o_done
);
  typedef enum logic [2:0] {
    H_IDLE = 3'h0,
    H_LO   = 3'h1,
    H_HI   = 3'h2,
    H_END  = 3'h3,
    H_GAP  = 3'h4
  } host_e;

  host_e       state;
  logic [7:0]  hc;
  logic [71:0] tx;
  logic [31:0] wd;
  logic [7:0]  op;
  logic [19:0] bidx;
  logic [19:0] dstart;
  logic [19:0] total;
  logic [7:0]  rx;
  logic [1:0]  msync;

  // Frame length: opcode, address, dummy, data; a boot write always carries four bytes
  wire [5:0]  a_bits = flash_cmd_pkg::cmd_addr_bits(i_opcode);
  wire [5:0]  d_bits = flash_cmd_pkg::cmd_dummy_bits(i_opcode);
  wire [15:0] n_data = flash_cmd_pkg::cmd_is_read(i_opcode) ? i_rd_bytes :
                       (i_opcode == flash_cmd_pkg::OP_BOOT_REG_WRITE) ? 16'd4 : 16'd0;
  wire [19:0] hdr = 20'(flash_cmd_pkg::OPCODE_BITS) + 20'(a_bits) + 20'(d_bits);
  wire [31:0] addr_al = i_addr << (6'd32 - a_bits);
  wire half_end = (hc == 8'(HALF - 1));
  wire [19:0] nb = bidx + 20'd1;
  wire in_dummy = (nb >= dstart - 20'(flash_cmd_pkg::cmd_dummy_bits(op))) && (nb < dstart);
  wire rd_bit = flash_cmd_pkg::cmd_is_read(op) && (bidx >= dstart);
  wire [7:0] rx_next = {rx[6:0], msync[1]};
  wire [19:0] rd_off = bidx - dstart;

  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      state <= H_IDLE;
      hc <= '0;
      tx <= '0;
      wd <= '0;
      op <= '0;
      bidx <= '0;
      dstart <= '0;
      total <= '0;
      rx <= '0;
      msync <= 2'b11;
      link.cs_n <= 1'b1;
      link.sclk <= 1'b0;
      link.mosi <= 1'b0;
      o_busy <= 1'b0;
      o_rdata <= '0;
      o_rvalid <= 1'b0;
      o_done <= 1'b0;
    end else begin
      msync <= {msync[0], link.miso_line};
      o_rvalid <= 1'b0;
      o_done <= 1'b0;
      hc <= half_end ? 8'h00 : hc + 8'h01;
      case (state)
        H_IDLE: begin
          hc <= '0;
          if (i_start) begin
            // Opcode then address left-aligned, MSB first
            tx <= {i_opcode, addr_al, 32'h00000000};
            wd <= i_wdata;
            op <= i_opcode;
            bidx <= '0;
            dstart <= hdr;
            total <= hdr + {n_data, 3'h0};
            link.cs_n <= 1'b0;
            link.mosi <= i_opcode[7];
            o_busy <= 1'b1;
            state <= H_LO;
          end
        end
        H_LO: begin
          if (half_end) begin
            link.sclk <= 1'b1;
            state <= H_HI;
          end
        end
        H_HI: begin
          if (half_end) begin
            link.sclk <= 1'b0;
            if (rd_bit) begin
              rx <= rx_next;
              if (rd_off[2:0] == 3'h7) begin
                o_rdata <= rx_next;
                o_rvalid <= 1'b1;
              end
            end
            bidx <= nb;
            if (nb == total) begin
              state <= H_END;
            end else begin
              state <= H_LO;
              if (nb == dstart) begin
                // Data phase reloads the shifter with the write word
                tx <= {wd, 40'h0000000000};
                link.mosi <= wd[31];
              end else if (in_dummy) begin
                link.mosi <= 1'b0;
              end else begin
                tx <= {tx[70:0], 1'b0};
                link.mosi <= tx[70];
              end
            end
          end
        end
        H_END: begin
          if (half_end) begin
            link.cs_n <= 1'b1;
            state <= H_GAP;
          end
        end
        H_GAP: begin
          // Deselect time before the next frame may begin
          if (half_end) begin
            o_busy <= 1'b0;
            o_done <= 1'b1;
            state <= H_IDLE;
          end
        end
        default: state <= H_IDLE;
      endcase
    end
  end
endmodule

/* spi_link_if.sv */
// Single-bit serial link between host controller and flash command decoder
interface spi_link_if;
  logic cs_n;
  logic sclk;
  logic mosi;
  logic miso;
  logic miso_oe;
  logic miso_line;

  // Undriven data line floats high through the board pull-up
  assign miso_line = miso_oe ? miso : 1'b1;

  modport device (input cs_n, input sclk, input mosi, output miso, output miso_oe);
  modport host   (output cs_n, output sclk, output mosi, input miso_line);
endinterface

/* tb_serial_flash_spi_command_decoder.sv */
// Self-checking bench: host controller and flash decoder joined across the serial link
module tb_serial_flash_spi_command_decoder;
  timeunit 1ns;
  timeprecision 1ps;

  typedef struct {
    logic [7:0]  op;
    logic [31:0] a;
    logic [15:0] n;
    logic [7:0]  ev;
    logic [7:0]  b0;
  } row_s;

  logic        i_mclk;
  logic        i_nrst;
  logic        i_start;
  logic [7:0]  i_opcode;
  logic [31:0] i_addr;
  logic [31:0] i_wdata;
  logic [15:0] i_rd_bytes;
  logic        o_busy;
  logic [7:0]  o_rdata;
  logic        o_rvalid;
  logic        o_done;
  logic [7:0]  o_op_pulse;
  logic        o_deep_sleep;
  logic        o_write_latch;
  logic [31:0] o_boot_value;
  logic [7:0]  seen;
  logic [7:0]  rx[$];
  int          mismatches = 0;
  int          checks = 0;
  int          i;
  int          k;
  row_s        rows[8];

  spi_link_if spi_link_if_i ();

  flash_host_ctrl #(.HALF(4)) flash_host_ctrl_i (
    .link(spi_link_if_i), .i_mclk(i_mclk), .i_nrst(i_nrst), .i_start(i_start), .i_opcode(i_opcode),
    .i_addr(i_addr), .i_wdata(i_wdata), .i_rd_bytes(i_rd_bytes), .o_busy(o_busy), .o_rdata(o_rdata),
    .o_rvalid(o_rvalid), .o_done(o_done));

  flash_cmd_decoder flash_cmd_decoder_i (
    .link(spi_link_if_i), .i_mclk(i_mclk), .i_nrst(i_nrst), .o_op_pulse(o_op_pulse),
    .o_deep_sleep(o_deep_sleep), .o_write_latch(o_write_latch), .o_boot_value(o_boot_value));

  flash_cmd_sva flash_cmd_sva_i (
    .i_mclk(i_mclk), .i_nrst(i_nrst), .cs_n(spi_link_if_i.cs_n), .sclk(spi_link_if_i.sclk),
    .mosi(spi_link_if_i.mosi), .miso(spi_link_if_i.miso), .miso_oe(spi_link_if_i.miso_oe),
    .miso_line(spi_link_if_i.miso_line));

  // 250 MHz user clock; the link clock is divided from it inside the host
  initial begin
    i_mclk = 1'b0;
    forever #2 i_mclk = ~i_mclk;
  end

  task automatic print_verdict();
    $display("checks=%0d mismatches=%0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // One whole frame: pulses and read bytes are gathered until the host reports the end
  task automatic cmd(input logic [7:0] op, input logic [31:0] a = 32'h0, input logic [31:0] w = 32'h0,
                     input logic [15:0] n = 16'h0);
    int t;
    rx.delete();
    seen = 8'h00;
    @(posedge i_mclk);
    i_start <= 1'b1;
    i_opcode <= op;
    i_addr <= a;
    i_wdata <= w;
    i_rd_bytes <= n;
    @(posedge i_mclk);
    i_start <= 1'b0;
    for (t = 0; t < 4000; t++) begin
      @(posedge i_mclk);
      if (t == 0) chk(o_busy, 1'b1);
      seen = seen | o_op_pulse;
      if (o_rvalid === 1'b1) rx.push_back(o_rdata);
      if (o_done === 1'b1) begin
        chk(o_busy, 1'b0);
        break;
      end
    end
    if (t == 4000) begin
      chk(32'h0, 32'h1);  // Hung frame counts as a mismatch
      print_verdict();
    end
    repeat (4) @(posedge i_mclk);
  endtask

  // Hold reset for 16 cycles; the host is the only party that moves the link clock
  task automatic do_reset();
    i_nrst <= 1'b0;
    repeat (16) @(posedge i_mclk);
    i_nrst <= 1'b1;
    @(posedge i_mclk);
  endtask

  initial begin
    i_nrst = 1'b0;
    i_start = 1'b0;
    i_opcode = 8'h00;
    i_addr = 32'h0;
    i_wdata = 32'h0;
    i_rd_bytes = 16'h0;
    rows = '{'{8'hB0, 32'h0, 16'h0, 8'h01, 8'h00},
             '{8'h30, 32'h0, 16'h0, 8'h02, 8'h00},
             '{8'h06, 32'h0, 16'h0, 8'h00, 8'h00},
             '{8'hE4, 32'h0, 16'h0, 8'h10, 8'h00},
             '{8'h0B, 32'h00123456, 16'h3, 8'h00, 8'h56},
             '{8'h0C, 32'h89ABCDEF, 16'h2, 8'h00, 8'hEF},
             '{8'hB9, 32'h0, 16'h0, 8'h08, 8'h00},
             '{8'hAB, 32'h0, 16'h0, 8'h04, 8'h00}};
    do_reset();
    chk(o_boot_value, 32'hFFFFFFFF);
    chk({o_write_latch, o_deep_sleep}, 32'h0);
    // Ordinary commands: expected pulses, and read bytes that count up from the low address byte
    for (i = 0; i < 8; i++) begin
      cmd(rows[i].op, rows[i].a, 32'h0, rows[i].n);
      chk(seen, rows[i].ev);
      chk(rx.size(), rows[i].n);
      for (k = 0; k < rx.size(); k++) chk(rx[k], rows[i].b0 + k[7:0]);
    end
    // Altering commands without the latch are refused
    cmd(8'hE4);
    chk(seen, 8'h00);
    cmd(8'h18);
    chk(seen, 8'h00);
    // Boot word written, read back cyclically in byte order, then erased
    cmd(8'h06);
    cmd(8'h17, 32'h0, 32'hA1B2C3D4);
    chk(seen, 8'h20);
    chk(o_boot_value, 32'hA1B2C3D4);
    chk(o_write_latch, 1'b0);
    cmd(8'h16, 32'h0, 32'h0, 16'h5);
    chk({rx[0], rx[1], rx[2], rx[3]}, 32'hA1B2C3D4);
    chk(rx[4], 8'hA1);
    cmd(8'h06);
    cmd(8'h18);
    chk(seen, 8'h40);
    chk(o_boot_value, 32'hFFFFFFFF);
    // Deep sleep ignores all but wake and the reset pair
    cmd(8'hB9);
    chk(o_deep_sleep, 1'b1);
    cmd(8'hB0);
    chk(seen, 8'h00);
    cmd(8'h06);
    chk(o_write_latch, 1'b0);
    cmd(8'hAB);
    chk(seen, 8'h04);
    chk(o_deep_sleep, 1'b0);
    // Two-step reset: fire alone, fire after an intervening command, then a proper pair
    cmd(8'h99);
    chk(seen, 8'h00);
    cmd(8'h66);
    cmd(8'h06);
    cmd(8'h99);
    chk(seen, 8'h00);
    cmd(8'h66);
    cmd(8'h99);
    chk(seen, 8'h80);
    chk(o_write_latch, 1'b0);
    // Undefined opcode: nothing happens
    cmd(8'h5A);
    chk(seen, 8'h00);
    // A read refused in deep sleep leaves the line to its pull-up; a reset pair then wakes the device
    cmd(8'hB9);
    cmd(8'h16, 32'h0, 32'h0, 16'h1);
    chk(rx.size(), 32'h1);
    chk(rx[0], 8'hFF);
    cmd(8'h66);
    cmd(8'h99);
    chk(seen, 8'h80);
    chk(o_deep_sleep, 1'b0);
    // Reset in mid-run drops the latch
    cmd(8'h06);
    chk(o_write_latch, 1'b1);
    do_reset();
    chk(o_write_latch, 1'b0);
    print_verdict();
  end
endmodule
